//--- core/vas_avg.sv
// Sample accumulator that averages a run of converter readings.
module vas_avg #(
	parameter int RES_BITS = vas_pkg::VAS_RES_BITS,
	parameter int COUNT = vas_pkg::VAS_AVG_COUNT
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Control
	input wire logic clear_in,
	input wire logic single_in,
	// Samples in
	input wire logic sample_valid_in,
	input wire logic [RES_BITS-1:0] sample_in,
	// Result out
	output logic done_out,
	output logic [RES_BITS-1:0] avg_out
);
	import vas_pkg::*;

	localparam int SHIFT = $clog2(COUNT);
	localparam int SUM_BITS = RES_BITS + SHIFT;

	logic [SUM_BITS-1:0] sum_reg;
	logic [SHIFT-1:0] cnt_reg;
	logic [SUM_BITS-1:0] sum_next;

	assign sum_next = sum_reg + SUM_BITS'(sample_in);

	// Running sum; unless single_in is set, a result only leaves once the full run is in, never a partial one.
	always_ff @(posedge clk_in) begin
		done_out <= 1'b0;
		if (reset_in || clear_in) begin
			sum_reg <= '0;
			cnt_reg <= '0;
			avg_out <= '0;
		end else if (sample_valid_in) begin
			if (single_in) begin
				avg_out <= sample_in;
				done_out <= 1'b1;
				sum_reg <= '0;
				cnt_reg <= '0;
			end else if (cnt_reg == SHIFT'(COUNT - 1)) begin
				avg_out <= sum_next[SUM_BITS-1:SHIFT];
				done_out <= 1'b1;
				sum_reg <= '0;
				cnt_reg <= '0;
			end else begin
				sum_reg <= sum_next;
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end
endmodule

//--- core/vas_top.sv
// Sequencer, averaging, limit checking and registers of the shared voltage converter.
module vas_top #(
	parameter int SAMPLE_CYCLES = vas_pkg::VAS_SAMPLE_CYCLES,
	parameter int RES_BITS = vas_pkg::VAS_RES_BITS
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Register byte port from the serial slave engine
	input wire logic byte_valid_in,
	input wire logic byte_first_in,
	input wire logic [7:0] byte_data_in,
	input wire logic rd_req_in,
	output logic [7:0] rd_data_out,
	output logic rd_valid_out,
	// Converter and multiplexer
	output logic conv_start_out,
	output logic [2:0] mux_sel_out,
	input wire logic sample_valid_in,
	input wire logic [RES_BITS-1:0] sample_in,
	output logic atten_bypass_out,
	output logic supply_5v_scale_out,
	// Results for the temperature path
	output logic result_valid_out,
	output logic [2:0] result_chan_out,
	output logic [RES_BITS-1:0] result_out,
	// Alert
	output logic smbalert_n_out
);
	import vas_pkg::*;

	localparam int TICK_BITS = $clog2(SAMPLE_CYCLES + 1);

	// ------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------

	// Only five of the eight select codes name a real input.
	function automatic logic chan_valid(input logic [2:0] code);
		chan_valid = (code == VAS_CH_CHIP) || (code == VAS_CH_SUP) ||
			(code == VAS_CH_REMOTE1) || (code == VAS_CH_LOCAL) ||
			(code == VAS_CH_REMOTE2);
	endfunction

	// Round-robin order through every input.
	function automatic logic [2:0] next_chan(input logic [2:0] code);
		if (code == VAS_CH_CHIP) begin
			next_chan = VAS_CH_SUP;
		end else if (code == VAS_CH_SUP) begin
			next_chan = VAS_CH_REMOTE1;
		end else if (code == VAS_CH_REMOTE1) begin
			next_chan = VAS_CH_LOCAL;
		end else if (code == VAS_CH_LOCAL) begin
			next_chan = VAS_CH_REMOTE2;
		end else begin
			next_chan = VAS_CH_CHIP;
		end
	endfunction

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic [7:0] ptr_reg;
	logic [7:0] main_cfg_reg;
	logic [7:0] conv_cfg_reg;
	logic [7:0] chan_sel_reg;
	logic [7:0] chip_low_reg;
	logic [7:0] chip_high_reg;
	logic [7:0] sup_low_reg;
	logic [7:0] sup_high_reg;
	logic [7:0] chip_val_reg;
	logic [7:0] sup_val_reg;
	logic [1:0] status_reg;
	logic [1:0] status_next;
	logic [TICK_BITS-1:0] tick_cnt_reg;
	logic tick_reg;
	vas_state_t state_reg;
	logic [2:0] chan_reg;
	logic data_wr;
	logic mode_wr;
	logic single_mode;
	logic one_shot;
	logic avg_done;
	logic [RES_BITS-1:0] avg_result;
	logic [7:0] res_hi;
	logic violation;
	logic [2:0] sel_code;

	assign data_wr = byte_valid_in && !byte_first_in;
	assign mode_wr = data_wr && ((ptr_reg == VAS_OFS_CONV_CFG) || (ptr_reg == VAS_OFS_CHAN_SEL));
	assign single_mode = conv_cfg_reg[VAS_BIT_SINGLE];
	assign one_shot = conv_cfg_reg[VAS_BIT_AVG_OFF] | single_mode;
	assign sel_code = chan_sel_reg[VAS_SEL_HI:VAS_SEL_LO];
	assign res_hi = avg_result[RES_BITS-1:RES_BITS-8];
	assign mux_sel_out = chan_reg;

	// ------------------------------------------------------------
	// Register write path
	// ------------------------------------------------------------

	// Address pointer takes the first byte of every write.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ptr_reg <= 8'h00;
		end else if (byte_valid_in && byte_first_in) begin
			ptr_reg <= byte_data_in;
		end
	end

	// Writable configuration and limits; value registers are not reachable from here.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			main_cfg_reg <= VAS_RST_CFG;
			conv_cfg_reg <= VAS_RST_CFG;
			chan_sel_reg <= VAS_RST_CFG;
			chip_low_reg <= VAS_RST_LOW;
			chip_high_reg <= VAS_RST_HIGH;
			sup_low_reg <= VAS_RST_LOW;
			sup_high_reg <= VAS_RST_HIGH;
		end else if (data_wr) begin
			if (ptr_reg == VAS_OFS_MAIN_CFG) begin
				main_cfg_reg <= byte_data_in;
			end else if (ptr_reg == VAS_OFS_CONV_CFG) begin
				conv_cfg_reg <= byte_data_in;
			end else if (ptr_reg == VAS_OFS_CHAN_SEL) begin
				chan_sel_reg <= byte_data_in;
			end else if (ptr_reg == VAS_OFS_CHIP_LOW) begin
				chip_low_reg <= byte_data_in;
			end else if (ptr_reg == VAS_OFS_CHIP_HIGH) begin
				chip_high_reg <= byte_data_in;
			end else if (ptr_reg == VAS_OFS_SUP_LOW) begin
				sup_low_reg <= byte_data_in;
			end else if (ptr_reg == VAS_OFS_SUP_HIGH) begin
				sup_high_reg <= byte_data_in;
			end
		end
	end

	// Analog control levels follow the configuration one cycle later.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			supply_5v_scale_out <= 1'b0;
			atten_bypass_out <= 1'b0;
		end else begin
			supply_5v_scale_out <= main_cfg_reg[VAS_BIT_SCALE_5V];
			atten_bypass_out <= conv_cfg_reg[VAS_BIT_BYPASS];
		end
	end

	// ------------------------------------------------------------
	// Register read path
	// ------------------------------------------------------------

	// Reads return the register under the pointer; unmapped offsets read as zero.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rd_data_out <= 8'h00;
			rd_valid_out <= 1'b0;
		end else begin
			rd_valid_out <= rd_req_in;
			if (rd_req_in) begin
				if (ptr_reg == VAS_OFS_CHIP_VAL) begin
					rd_data_out <= chip_val_reg;
				end else if (ptr_reg == VAS_OFS_SUP_VAL) begin
					rd_data_out <= sup_val_reg;
				end else if (ptr_reg == VAS_OFS_MAIN_CFG) begin
					rd_data_out <= main_cfg_reg;
				end else if (ptr_reg == VAS_OFS_STATUS) begin
					rd_data_out <= {6'h00, status_reg};
				end else if (ptr_reg == VAS_OFS_CHIP_LOW) begin
					rd_data_out <= chip_low_reg;
				end else if (ptr_reg == VAS_OFS_CHIP_HIGH) begin
					rd_data_out <= chip_high_reg;
				end else if (ptr_reg == VAS_OFS_SUP_LOW) begin
					rd_data_out <= sup_low_reg;
				end else if (ptr_reg == VAS_OFS_SUP_HIGH) begin
					rd_data_out <= sup_high_reg;
				end else if (ptr_reg == VAS_OFS_CHAN_SEL) begin
					rd_data_out <= chan_sel_reg;
				end else if (ptr_reg == VAS_OFS_CONV_CFG) begin
					rd_data_out <= conv_cfg_reg;
				end else begin
					rd_data_out <= 8'h00;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Sample rate divider
	// ------------------------------------------------------------

	// One-cycle enable every sample period.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (tick_cnt_reg == TICK_BITS'(SAMPLE_CYCLES - 1)) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
			tick_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Channel sequencer
	// ------------------------------------------------------------

	// Starts one conversion per tick on the current channel; in single mode, on the selected code only if it is valid. A tick that lands while a
	// conversion is still outstanding is dropped rather than queued.
	always_ff @(posedge clk_in) begin
		conv_start_out <= 1'b0;
		if (reset_in) begin
			state_reg <= VAS_WAIT_TICK;
			chan_reg <= VAS_CH_CHIP;
		end else begin
			case (state_reg)
				VAS_WAIT_TICK: begin
					if (tick_reg) begin
						if (single_mode) begin
							if (chan_valid(sel_code)) begin
								chan_reg <= sel_code;
								conv_start_out <= 1'b1;
								state_reg <= VAS_WAIT_SAMPLE;
							end
						end else begin
							conv_start_out <= 1'b1;
							state_reg <= VAS_WAIT_SAMPLE;
						end
					end
				end
				VAS_WAIT_SAMPLE: begin
					if (sample_valid_in) begin
						state_reg <= VAS_WAIT_TICK;
					end
				end
				default: begin
					state_reg <= VAS_WAIT_TICK;
				end
			endcase
			if (avg_done && !single_mode) begin
				chan_reg <= next_chan(chan_reg);
			end
		end
	end

	// ------------------------------------------------------------
	// Averaging
	// ------------------------------------------------------------

	// A mode or selector write restarts the run so no mixed-channel average is stored.
	vas_avg #(
		.RES_BITS(RES_BITS),
		.COUNT(VAS_AVG_COUNT)
	) u_avg (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.clear_in(mode_wr),
		.single_in(one_shot),
		.sample_valid_in(sample_valid_in && (state_reg == VAS_WAIT_SAMPLE)),
		.sample_in(sample_in),
		.done_out(avg_done),
		.avg_out(avg_result)
	);

	// ------------------------------------------------------------
	// Results and limit checking
	// ------------------------------------------------------------

	// Rail values take only finished results (full averages, or single readings when one_shot is set); the full 10-bit code, where the nominal
	// input sits at three-quarter scale, goes out for every channel.
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			chip_val_reg <= VAS_RST_VALUE;
			sup_val_reg <= VAS_RST_VALUE;
			result_valid_out <= 1'b0;
			result_chan_out <= 3'h0;
			result_out <= '0;
		end else begin
			result_valid_out <= avg_done;
			if (avg_done) begin
				result_chan_out <= chan_reg;
				result_out <= avg_result;
				if (chan_reg == VAS_CH_CHIP) begin
					chip_val_reg <= res_hi;
				end else if (chan_reg == VAS_CH_SUP) begin
					sup_val_reg <= res_hi;
				end
			end
		end
	end

	// Strict comparison of the upper eight bits with the channel's limits.
	always_comb begin
		violation = 1'b0;
		if (chan_reg == VAS_CH_CHIP) begin
			violation = (res_hi > chip_high_reg) || (res_hi < chip_low_reg);
		end else if (chan_reg == VAS_CH_SUP) begin
			violation = (res_hi > sup_high_reg) || (res_hi < sup_low_reg);
		end
	end

	// Sticky status cleared by reading it; a fresh violation in that cycle still sets.
	always_comb begin
		status_next = status_reg;
		if (rd_req_in && (ptr_reg == VAS_OFS_STATUS)) begin
			status_next = 2'b00;
		end
		if (avg_done && violation) begin
			if (chan_reg == VAS_CH_CHIP) begin
				status_next[VAS_ST_CHIP] = 1'b1;
			end else begin
				status_next[VAS_ST_SUP] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			status_reg <= 2'b00;
			smbalert_n_out <= 1'b1;
		end else begin
			status_reg <= status_next;
			smbalert_n_out <= ~|status_reg;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------

	sequence s_chip_over;
		avg_done && (chan_reg == VAS_CH_CHIP) && (res_hi > chip_high_reg);
	endsequence

	sequence s_tick_gap;
		!tick_reg [*3];
	endsequence

	AST_LIMIT_RESET: assert property (@(posedge clk_in) reset_in |=>
		(chip_low_reg == 8'h00) && (chip_high_reg == 8'hff) && (sup_high_reg == 8'hff))
		else $error("limit registers wrong after reset");

	AST_ALERT_LOW: assert property (@(posedge clk_in) disable iff (reset_in)
		(|status_reg) |=> !smbalert_n_out)
		else $error("alert not driven low on status");

	AST_CHIP_FLAG: assert property (@(posedge clk_in) disable iff (reset_in)
		s_chip_over |=> status_reg[VAS_ST_CHIP] ##1 !smbalert_n_out)
		else $error("chipset rail violation not flagged");

	AST_VALUE_FULL: assert property (@(posedge clk_in) disable iff (reset_in)
		$changed(chip_val_reg) |-> $past(avg_done))
		else $error("value register changed without a finished average");

	AST_SCALE_FOLLOW: assert property (@(posedge clk_in) disable iff (reset_in)
		##1 supply_5v_scale_out == $past(main_cfg_reg[VAS_BIT_SCALE_5V]))
		else $error("supply scale does not follow bit 7");

	AST_BYPASS_FOLLOW: assert property (@(posedge clk_in) disable iff (reset_in)
		##1 atten_bypass_out == $past(conv_cfg_reg[VAS_BIT_BYPASS]))
		else $error("attenuator bypass does not follow bit 5");

	AST_SINGLE_SEL: assert property (@(posedge clk_in) disable iff (reset_in)
		(tick_reg && single_mode && (state_reg == VAS_WAIT_TICK) && chan_valid(sel_code))
		|=> conv_start_out && (mux_sel_out == $past(sel_code)))
		else $error("single mode started the wrong channel");

	AST_TICK_SPACING: assert property (@(posedge clk_in) disable iff (reset_in)
		tick_reg |=> s_tick_gap)
		else $error("sample ticks too close together");

	AST_ONE_SHOT: assert property (@(posedge clk_in) disable iff (reset_in || mode_wr)
		(one_shot && sample_valid_in && (state_reg == VAS_WAIT_SAMPLE)) |=> avg_done)
		else $error("averaging off did not store the single reading");
endmodule

//--- dv/tb.sv
// Self-checking bench for the voltage converter sequencer.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import vas_pkg::*;

	// Short sample period keeps a full round of measurements near 640 cycles.
	localparam int SC = 8;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic byte_valid_in = 1'b0;
	logic byte_first_in = 1'b0;
	logic [7:0] byte_data_in = 8'h00;
	logic rd_req_in = 1'b0;
	logic [2:0] lag = 3'h1;
	logic [9:0] code = 10'h301;
	logic [7:0] rd_data_out;
	logic rd_valid_out, conv_start_out, sample_valid_in, atten_bypass_out;
	logic supply_5v_scale_out, result_valid_out, smbalert_n_out;
	logic [2:0] mux_sel_out, result_chan_out;
	logic [9:0] sample_in, result_out;
	int fails = 0;
	int checks = 0;
	int n_start = 0;
	int gap = 0;
	logic [2:0] chq[$];
	logic [9:0] resq[$];
	int stq[$];
	int gapq[$];
	logic [2:0] rr[5] = '{VAS_CH_CHIP, VAS_CH_SUP, VAS_CH_REMOTE1, VAS_CH_LOCAL, VAS_CH_REMOTE2};

	vas_top #(.SAMPLE_CYCLES(SC)) dut (.clk_in(clk_in), .reset_in(reset_in),
		.byte_valid_in(byte_valid_in), .byte_first_in(byte_first_in),
		.byte_data_in(byte_data_in), .rd_req_in(rd_req_in), .rd_data_out(rd_data_out),
		.rd_valid_out(rd_valid_out), .conv_start_out(conv_start_out), .mux_sel_out(mux_sel_out),
		.sample_valid_in(sample_valid_in), .sample_in(sample_in),
		.atten_bypass_out(atten_bypass_out), .supply_5v_scale_out(supply_5v_scale_out),
		.result_valid_out(result_valid_out), .result_chan_out(result_chan_out),
		.result_out(result_out), .smbalert_n_out(smbalert_n_out));

	vas_conv_model conv (.clk_in(clk_in), .reset_in(reset_in), .conv_start_in(conv_start_out),
		.mux_sel_in(mux_sel_out), .lag_in(lag), .code_in(code),
		.sample_valid_out(sample_valid_in), .sample_out(sample_in));

	// ------------------------------------------------------------
	// Clock, monitor and comparisons
	// ------------------------------------------------------------
	initial begin
		forever #2 clk_in = ~clk_in;
	end

	// Logs each finished measurement with its start count and spacing.
	always @(posedge clk_in) begin
		if (conv_start_out === 1'b1) n_start++;
		if (result_valid_out === 1'b1) begin
			chq.push_back(result_chan_out);
			resq.push_back(result_out);
			stq.push_back(n_start);
			gapq.push_back(gap);
			n_start = 0;
			gap = 0;
		end
		gap++;
	end

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_word(input logic [9:0] got, input logic [9:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_num(input int got, input int exp, input string m);
		checks++;
		if (got != exp) begin
			fails++;
			$display("wrong value at %0t: %s got %0d want %0d", $time, m, got, exp);
		end
	endtask

	// ------------------------------------------------------------
	// Host side of the register byte port
	// ------------------------------------------------------------
	// Valid stays high across both bytes so no signal is driven twice in one step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		byte_valid_in <= 1'b1;
		byte_first_in <= 1'b1;
		byte_data_in <= a;
		@(posedge clk_in);
		byte_first_in <= 1'b0;
		byte_data_in <= d;
		@(posedge clk_in);
		byte_valid_in <= 1'b0;
		@(posedge clk_in);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		byte_valid_in <= 1'b1;
		byte_first_in <= 1'b1;
		byte_data_in <= a;
		@(posedge clk_in);
		byte_valid_in <= 1'b0;
		rd_req_in <= 1'b1;
		@(posedge clk_in);
		rd_req_in <= 1'b0;
		#1;
		chk_byte({7'h00, rd_valid_out}, 8'h01, "read valid");
		chk_byte(rd_data_out, exp, "read data");
		@(posedge clk_in);
	endtask

	// Drops the measurement in flight when called, then collects n whole ones.
	task automatic wait_results(input int n);
		int k;
		chq.delete();
		resq.delete();
		stq.delete();
		gapq.delete();
		for (k = 0; k < 4000 && chq.size() < n + 1; k++) @(posedge clk_in);
		chk_num(chq.size() >= n + 1, 1, "measurements finished");
	endtask

	function automatic logic [9:0] base(input logic [2:0] c);
		return (c === VAS_CH_CHIP || c === VAS_CH_SUP) ? code : 10'h101;
	endfunction

	task automatic endtest(input string name);
		$display("test %s done", name);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] ofs[10] = '{8'h21, 8'h22, 8'h40, 8'h46, 8'h47, 8'h48, 8'h49, 8'h55, 8'h73, 8'h10};
		logic [7:0] val[10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 10; i++) rd_chk(ofs[i], val[i]);
		chk_byte({7'h00, smbalert_n_out}, 8'h01, "alert idle");
		wr(8'h47, 8'h80);
		rd_chk(8'h47, 8'h80);
		wr(8'h21, 8'h55);
		rd_chk(8'h21, 8'h00);
		wr(8'h47, 8'hff);
		endtest("reset");
	endtask

	task automatic t_avg();
		int j;
		lag = 3'h5;
		wait_results(6);
		for (int i = 1; i <= 6; i++) begin
			chk_num(stq[i], VAS_AVG_COUNT, "starts per measurement");
			chk_word(resq[i], base(chq[i]), "averaged result");
			j = 0;
			while (j < 4 && rr[j] !== chq[i - 1]) j++;
			chk_byte({5'h00, chq[i]}, {5'h00, rr[(j + 1) % 5]}, "round robin");
		end
		rd_chk(VAS_OFS_CHIP_VAL, 8'hc0);
		rd_chk(VAS_OFS_SUP_VAL, 8'hc0);
		lag = 3'h1;
		endtest("averaging");
	endtask

	task automatic t_avg_off();
		wr(VAS_OFS_CONV_CFG, 8'h10);
		wait_results(6);
		for (int i = 1; i <= 6; i++) begin
			chk_num(stq[i], 1, "starts per reading");
			chk_num(resq[i] === base(chq[i]) + 10'h001 || resq[i] === base(chq[i]) - 10'h001,
				1, "single reading stored");
		end
		endtest("averaging off");
	endtask

	task automatic t_single();
		logic [2:0] c;
		wr(VAS_OFS_MAIN_CFG, 8'h80);
		// The level changes on the edge that ends the write, so look once it has settled.
		#1;
		chk_byte({7'h00, supply_5v_scale_out}, 8'h01, "5 V scaling");
		wr(VAS_OFS_CONV_CFG, 8'h60);
		#1;
		chk_byte({7'h00, atten_bypass_out}, 8'h01, "attenuator bypass");
		for (int i = 0; i < 5; i++) begin
			c = rr[i];
			wr(VAS_OFS_CHAN_SEL, {c, 5'h00});
			wait_results(3);
			for (int k = 1; k <= 3; k++) begin
				chk_byte({5'h00, chq[k]}, {5'h00, c}, "selected channel");
				chk_num(gapq[k], SC, "reconversion period");
			end
			chk_byte({5'h00, mux_sel_out}, {5'h00, c}, "mux select");
		end
		wr(VAS_OFS_CHAN_SEL, 8'h00);
		repeat (20) @(posedge clk_in);
		#1 n_start = 0;
		repeat (40) @(posedge clk_in);
		chk_num(n_start, 0, "no conversion on invalid select");
		wr(VAS_OFS_MAIN_CFG, 8'h00);
		#1;
		chk_byte({7'h00, supply_5v_scale_out}, 8'h00, "5 V scaling off");
		endtest("single channel");
	endtask

	task automatic t_limits();
		wr(VAS_OFS_CONV_CFG, 8'h40);
		wr(VAS_OFS_CHAN_SEL, 8'h20);
		wr(VAS_OFS_CHIP_HIGH, 8'hc0);
		wr(VAS_OFS_CHIP_LOW, 8'hc0);
		wait_results(2);
		wr(VAS_OFS_STATUS, 8'h00);
		rd_chk(VAS_OFS_STATUS, 8'h00);
		wait_results(2);
		rd_chk(VAS_OFS_STATUS, 8'h00);
		chk_byte({7'h00, smbalert_n_out}, 8'h01, "no alert at limit");
		wr(VAS_OFS_CHIP_HIGH, 8'hbf);
		wait_results(2);
		chk_byte({7'h00, smbalert_n_out}, 8'h00, "alert on high");
		rd_chk(VAS_OFS_STATUS, 8'h01);
		wr(VAS_OFS_CHIP_HIGH, 8'hff);
		wr(VAS_OFS_CHIP_LOW, 8'hc1);
		wait_results(2);
		rd_chk(VAS_OFS_STATUS, 8'h01);
		wr(VAS_OFS_CHIP_LOW, 8'h00);
		wait_results(1);
		wr(VAS_OFS_CHAN_SEL, 8'h40);
		wr(VAS_OFS_SUP_HIGH, 8'hbf);
		wait_results(2);
		rd_chk(VAS_OFS_STATUS, 8'h02);
		wr(VAS_OFS_SUP_HIGH, 8'hff);
		wait_results(1);
		wr(VAS_OFS_STATUS, 8'h00);
		rd_chk(VAS_OFS_STATUS, 8'h00);
		repeat (3) @(posedge clk_in);
		chk_byte({7'h00, smbalert_n_out}, 8'h01, "alert released");
		endtest("limits");
	endtask

	// ------------------------------------------------------------
	// Sequence, watchdog and verdict
	// ------------------------------------------------------------
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		t_reset();
		t_avg();
		t_avg_off();
		t_single();
		t_limits();
		tally_and_finish();
	end

	// The tests need about 1500 cycles; over twenty-five times that means a hang.
	initial begin
		repeat (40000) @(posedge clk_in);
		fails++;
		$display("wrong value at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule

//--- dv/vas_conv_model.sv
// Behavioural converter that answers the sequencer's start pulses.
module vas_conv_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// From the sequencer
	input wire logic conv_start_in,
	input wire logic [2:0] mux_sel_in,
	// Bench controls
	input wire logic [2:0] lag_in,
	input wire logic [9:0] code_in,
	// Result back to the sequencer
	output logic sample_valid_out,
	output logic [9:0] sample_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] wait_reg;
	logic [2:0] chan_reg;
	logic busy_reg;
	logic dither_reg;

	// ------------------------------------------------------------
	// Conversion timing
	// ------------------------------------------------------------
	// Each result alternates one code above and below the base, so a single
	// reading never equals the average of an even run of readings.
	always_ff @(posedge clk_in) begin
		sample_valid_out <= 1'b0;
		sample_out <= ~sample_out; // Idle data keeps moving, never a stale result.
		if (reset_in) begin
			busy_reg <= 1'b0;
			dither_reg <= 1'b0;
			wait_reg <= 3'h0;
			chan_reg <= 3'h0;
			sample_out <= 10'h000;
		end else if (conv_start_in) begin
			busy_reg <= 1'b1;
			wait_reg <= lag_in;
			chan_reg <= mux_sel_in;
		end else if (busy_reg && wait_reg <= 3'h1) begin
			busy_reg <= 1'b0;
			dither_reg <= ~dither_reg;
			sample_valid_out <= 1'b1;
			sample_out <= ((chan_reg <= 3'h2) ? code_in : 10'h101) + (dither_reg ? 10'h001 : 10'h3ff);
		end else if (busy_reg) begin
			wait_reg <= wait_reg - 3'h1;
		end
	end
endmodule

//--- include/vas_pkg.sv
// Constants shared by the voltage converter sequencer.
package vas_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] VAS_OFS_CHIP_VAL = 8'h21;
	localparam logic [7:0] VAS_OFS_SUP_VAL = 8'h22;
	localparam logic [7:0] VAS_OFS_MAIN_CFG = 8'h40;
	localparam logic [7:0] VAS_OFS_STATUS = 8'h41;
	localparam logic [7:0] VAS_OFS_CHIP_LOW = 8'h46;
	localparam logic [7:0] VAS_OFS_CHIP_HIGH = 8'h47;
	localparam logic [7:0] VAS_OFS_SUP_LOW = 8'h48;
	localparam logic [7:0] VAS_OFS_SUP_HIGH = 8'h49;
	localparam logic [7:0] VAS_OFS_CHAN_SEL = 8'h55;
	localparam logic [7:0] VAS_OFS_CONV_CFG = 8'h73;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int VAS_BIT_SCALE_5V = 7;
	localparam int VAS_BIT_AVG_OFF = 4;
	localparam int VAS_BIT_BYPASS = 5;
	localparam int VAS_BIT_SINGLE = 6;
	localparam int VAS_SEL_HI = 7;
	localparam int VAS_SEL_LO = 5;
	localparam int VAS_ST_CHIP = 0;
	localparam int VAS_ST_SUP = 1;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] VAS_RST_VALUE = 8'h00;
	localparam logic [7:0] VAS_RST_LOW = 8'h00;
	localparam logic [7:0] VAS_RST_HIGH = 8'hff;
	localparam logic [7:0] VAS_RST_CFG = 8'h00;

	// ------------------------------------------------------------
	// Channel codes and converter scale
	// ------------------------------------------------------------
	localparam logic [2:0] VAS_CH_CHIP = 3'h1;
	localparam logic [2:0] VAS_CH_SUP = 3'h2;
	localparam logic [2:0] VAS_CH_REMOTE1 = 3'h5;
	localparam logic [2:0] VAS_CH_LOCAL = 3'h6;
	localparam logic [2:0] VAS_CH_REMOTE2 = 3'h7;
	localparam int VAS_RES_BITS = 10;
	localparam logic [9:0] VAS_NOMINAL_CODE = 10'h300;
	localparam int VAS_AVG_COUNT = 16;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int VAS_CLK_PERIOD_PS = 4000;
	localparam int VAS_SAMPLE_TIME_US = 700;
	localparam int VAS_MEAS_TIME_MS = 11;
	localparam int VAS_SAMPLE_CYCLES = (VAS_SAMPLE_TIME_US * 1000000) / VAS_CLK_PERIOD_PS;

	typedef enum logic {
		VAS_WAIT_TICK,
		VAS_WAIT_SAMPLE
	} vas_state_t;

endpackage
